// [hsw_pkg.sv]
// Purpose: Shared types and constants for head select and write clocking
// Assumes: One 10 MHz system clock; all pins sampled on it
// Notes:   Arm enables are one-hot for a legal head and all zero otherwise, bit 0 is arm 1
package hsw_pkg;
    // ==================================================
    // Head addressing
    localparam logic [3:0] HSW_MAX_HEAD = 4'he;
    localparam int         HSW_NUM_ARM  = 8;
    // Arm enable per head pair, head number bits 3:1 index it
    localparam logic [7:0] HSW_ARM_MAP [0:7] = '{
        8'h20, 8'h40, 8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
    localparam logic [7:0] HSW_ARM_NONE = 8'h00;

    // ==================================================
    // Clock dividers and encoder
    localparam logic [1:0] HSW_FB_DIV_LAST = 2'h2; // Divide by three
    localparam logic [4:0] HSW_Q_EMPTY     = 5'h00;
    localparam logic [2:0] HSW_BUF_EMPTY   = 3'h0;

    // ==================================================
    // Write state machine
    typedef enum logic [2:0] {
        HSW_WR_IDLE   = 3'h1,
        HSW_WR_ACTIVE = 3'h2,
        HSW_WR_FAULT  = 3'h4
    } hsw_wr_state_t;

    // ==================================================
    // Carriers
    typedef struct packed {
        logic [7:0] arm_en;      // One-hot arm preamplifier enable
        logic       head_choice; // Head on the enabled arm
        logic [3:0] addr;        // Head number holding register
    } hsw_sel_t;

    typedef struct packed {
        logic pump_up;
        logic pump_down;
        logic base_clk;  // base_transfer_rate_clock
        logic half_clk;  // half_rate_clock
    } hsw_pll_t;

    typedef struct packed {
        logic write_enable;
        logic write_fault;
        logic data_p;    // polarity_flip_stage true line
        logic data_n;    // polarity_flip_stage complement line
    } hsw_wr_t;
endpackage : hsw_pkg

// [hsw_head_write.sv]
// Purpose: Head selection decode and write path front end of a disc drive
// Assumes: Pins synchronous to sys_clk; vco_clk_in, ref_clk_in and
//          write_clk_in are sampled levels much slower than sys_clk
// Notes:   Compensation is the nominal path only; no early/late shifts
`timescale 1ns/1ps

module hsw_head_write
    import hsw_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       on_cylinder,
    input  wire logic       head_sel_cmd,
    input  wire logic [3:0] head_number,
    input  wire logic       write_gate,
    input  wire logic       write_data_nrz,
    input  wire logic       write_clk_in,
    input  wire logic       fault_clear,
    input  wire logic       servo_decoding,
    input  wire logic       vco_clk_in,
    input  wire logic       ref_clk_in,
    output hsw_sel_t        sel_out,
    output hsw_pll_t        pll_out,
    output hsw_wr_t         wr_out
);
    // ==================================================
    // Reset release
    logic          rst_meta_ff;
    logic          rst_n_ff;
    // Selection
    hsw_sel_t      sel_ff;
    logic          head_ok_ff;
    // Loop
    logic          vco_d_ff;
    logic          ref_d_ff;
    logic          base_ff;
    logic          half_ff;
    logic          half_d_ff;
    logic [1:0]    div3_ff;
    logic          pend_fb_ff;
    logic          pend_ref_ff;
    logic          pump_up_ff;
    logic          pump_dn_ff;
    // Write path
    hsw_wr_state_t wr_state_ff;
    hsw_wr_state_t nxt_wr_state;
    logic          wclk_d_ff;
    logic [3:0]    nrz_buf_ff;
    logic [2:0]    nrz_len_ff;
    logic [15:0]   out_q_ff;
    logic [4:0]    out_cnt_ff;
    logic [15:0]   nxt_out_q;
    logic [4:0]    nxt_out_cnt;
    logic          enc_bit_ff;
    logic [1:0]    comp_ff;
    logic          flip_ff;
    logic          wen_ff;
    // Decoded events
    logic          tick_2f;
    logic          ref_edge;
    logic          fb_edge;
    logic          wclk_edge;
    logic          take_bit;
    logic [3:0]    nb;
    logic [2:0]    nl;
    logic          hit;
    logic [3:0]    clen;
    logic [7:0]    code;

    // ==================================================
    // Two flip-flop reset release; async assert
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            {rst_meta_ff, rst_n_ff} <= '0;
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ==================================================
    // Head selection: command ignored while the actuator seeks
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {sel_ff, head_ok_ff} <= '0;
        else if (head_sel_cmd && on_cylinder)
        begin
            sel_ff.addr        <= head_number;
            sel_ff.head_choice <= head_number[0];
            // Decode straight from the pins so outputs stay registered
            if (head_number > HSW_MAX_HEAD)
            begin
                sel_ff.arm_en <= HSW_ARM_NONE;
                head_ok_ff    <= 1'b0;
            end
            else
            begin
                sel_ff.arm_en <= HSW_ARM_MAP[head_number[3:1]];
                head_ok_ff    <= 1'b1;
            end
        end
    end

    // ==================================================
    // Edge sampling of slow clock levels
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {vco_d_ff, ref_d_ff, wclk_d_ff, half_d_ff} <= '0;
        else
        begin
            vco_d_ff  <= vco_clk_in;
            ref_d_ff  <= ref_clk_in;
            wclk_d_ff <= write_clk_in;
            half_d_ff <= half_ff;
        end
    end

    assign tick_2f   = vco_clk_in && !vco_d_ff && servo_decoding;
    assign ref_edge  = ref_clk_in && !ref_d_ff && servo_decoding;
    assign wclk_edge = write_clk_in && !wclk_d_ff;
    assign fb_edge   = half_ff && !half_d_ff && (div3_ff == HSW_FB_DIV_LAST);

    // ==================================================
    // Dividers; held cleared while servo is not decoded
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {base_ff, half_ff, div3_ff} <= '0;
        else if (!servo_decoding)
            {base_ff, half_ff, div3_ff} <= '0;
        else
        begin
            if (tick_2f)
                base_ff <= !base_ff;
            if (tick_2f && base_ff)
                half_ff <= !half_ff;
            if (half_ff && !half_d_ff)
                div3_ff <= (div3_ff == HSW_FB_DIV_LAST) ? 2'h0 : div3_ff + 2'h1;
        end
    end

    // ==================================================
    // Coincidence comparator: pump width follows phase error
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {pend_fb_ff, pend_ref_ff, pump_up_ff, pump_dn_ff} <= '0;
        else
        begin
            if (fb_edge && ref_edge)
            begin
                pend_fb_ff  <= 1'b0;
                pend_ref_ff <= 1'b0;
            end
            else if (fb_edge)
            begin
                pend_fb_ff  <= !pend_ref_ff;
                pend_ref_ff <= 1'b0;
            end
            else if (ref_edge)
            begin
                pend_ref_ff <= !pend_fb_ff;
                pend_fb_ff  <= 1'b0;
            end
            pump_dn_ff <= pend_fb_ff;  // Feedback led
            pump_up_ff <= pend_ref_ff; // Feedback lags
        end
    end

    // ==================================================
    // Write state: fault sticks until cleared, set wins
    always_comb
    begin
        nxt_wr_state = wr_state_ff;
        case (wr_state_ff)
            HSW_WR_IDLE, HSW_WR_ACTIVE:
            begin
                if (write_gate && !head_ok_ff)
                    nxt_wr_state = HSW_WR_FAULT;
                else if (write_gate)
                    nxt_wr_state = HSW_WR_ACTIVE;
                else
                    nxt_wr_state = HSW_WR_IDLE;
            end
            HSW_WR_FAULT:
            begin
                if (fault_clear && !(write_gate && !head_ok_ff))
                    nxt_wr_state = HSW_WR_IDLE;
            end
            default:
                nxt_wr_state = HSW_WR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            wr_state_ff <= HSW_WR_IDLE;
        else
            wr_state_ff <= nxt_wr_state;
    end

    // ==================================================
    // NRZ word recognition; bits taken on returned write clock
    assign take_bit = wclk_edge && write_gate;
    assign nb       = {nrz_buf_ff[2:0], write_data_nrz};
    assign nl       = nrz_len_ff + 3'h1;

    always_comb
    begin
        hit  = 1'b1;
        clen = 4'h0;
        code = 8'h00;
        case ({nl, nb})
            {3'h2, 4'h0}: begin clen = 4'h4; code = 8'h80; end
            {3'h2, 4'h1}: begin clen = 4'h4; code = 8'h40; end
            {3'h3, 4'h4}: begin clen = 4'h6; code = 8'h20; end
            {3'h3, 4'h5}: begin clen = 4'h6; code = 8'h90; end
            {3'h3, 4'h7}: begin clen = 4'h6; code = 8'h10; end
            {3'h4, 4'hc}: begin clen = 4'h8; code = 8'h08; end
            {3'h4, 4'hd}: begin clen = 4'h8; code = 8'h24; end
            default:      hit  = 1'b0;
        endcase
        hit = hit && take_bit;
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {nrz_buf_ff, nrz_len_ff} <= '0;
        else if (!write_gate)
            {nrz_buf_ff, nrz_len_ff} <= '0;
        else if (take_bit)
        begin
            nrz_buf_ff <= hit ? 4'h0 : nb;
            nrz_len_ff <= hit ? HSW_BUF_EMPTY : nl;
        end
    end

    // ==================================================
    // Output queue: words appended, one code bit per 2F tick
    always_comb
    begin
        nxt_out_q   = out_q_ff;
        nxt_out_cnt = out_cnt_ff;
        if (tick_2f && out_cnt_ff != HSW_Q_EMPTY)
        begin
            nxt_out_q   = {out_q_ff[14:0], 1'b0};
            nxt_out_cnt = out_cnt_ff - 5'h01;
        end
        if (hit)
        begin
            nxt_out_q   = nxt_out_q | ({code, 8'h00} >> nxt_out_cnt);
            nxt_out_cnt = nxt_out_cnt + {1'b0, clen};
        end
    end

    // Encoder, compensation, polarity stage in that order
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {out_q_ff, out_cnt_ff, enc_bit_ff, comp_ff} <= '0;
        else if (!write_gate)
            {out_q_ff, out_cnt_ff, enc_bit_ff, comp_ff} <= '0;
        else
        begin
            out_q_ff   <= nxt_out_q;
            out_cnt_ff <= nxt_out_cnt;
            if (tick_2f)
            begin
                enc_bit_ff <= (out_cnt_ff != HSW_Q_EMPTY) && out_q_ff[15];
                comp_ff    <= {comp_ff[0], enc_bit_ff};
            end
        end
    end

    // Stage cleared whenever writing is not enabled
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            {flip_ff, wen_ff} <= '0;
        else
        begin
            wen_ff <= write_gate && head_ok_ff && nxt_wr_state == HSW_WR_ACTIVE;
            if (!wen_ff)
                flip_ff <= 1'b0;
            else if (tick_2f && comp_ff[1])
                flip_ff <= !flip_ff;
        end
    end

    // ==================================================
    // Outputs
    assign sel_out = sel_ff;
    assign pll_out = '{pump_up: pump_up_ff, pump_down: pump_dn_ff,
                       base_clk: base_ff, half_clk: half_ff};
    assign wr_out  = '{write_enable: wen_ff,
                       write_fault: wr_state_ff == HSW_WR_FAULT,
                       data_p: flip_ff, data_n: !flip_ff};

    // ==================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_ff);

    a_sel_off_cyl: assert property (
        head_sel_cmd && !on_cylinder |=> $stable(sel_ff))
        else $error("select taken off cylinder");
    a_sel_load: assert property (
        head_sel_cmd && on_cylinder |=> sel_ff.addr == $past(head_number))
        else $error("holding register not loaded");
    a_arm_onehot: assert property (
        head_ok_ff |-> $onehot(sel_ff.arm_en))
        else $error("arm enable not one-hot");
    a_illegal_none: assert property (
        head_sel_cmd && on_cylinder && head_number == 4'hf |=> sel_ff.arm_en == 8'h00)
        else $error("illegal head selected an arm");
    a_head_line0: assert property (
        sel_ff.head_choice == sel_ff.addr[0])
        else $error("head choice not address line 0");
    a_wfault_set: assert property (
        write_gate && !head_ok_ff |=> wr_out.write_fault ##1 (wr_out.write_fault || $past(fault_clear)))
        else $error("write fault missing");
    a_wen_gate: assert property (
        wen_ff |-> $past(write_gate) && $past(head_ok_ff))
        else $error("write enabled without gate or head");
    a_flip_one: assert property (
        wen_ff && $past(wen_ff) && $past(tick_2f) && $past(comp_ff[1]) |-> flip_ff != $past(flip_ff))
        else $error("polarity did not flip");
    a_base_half: assert property (
        servo_decoding && tick_2f |=> base_ff != $past(base_ff))
        else $error("base clock not halved");
    a_pump_excl: assert property (
        !(pump_up_ff && pump_dn_ff))
        else $error("pump up and down together");

    c_sel_legal: cover property (head_sel_cmd && on_cylinder && head_number == 4'he);
    c_write_run: cover property (wen_ff ##1 flip_ff);
    c_fault: cover property (wr_out.write_fault ##1 fault_clear);
    c_pump_dn: cover property (pump_dn_ff ##1 !pump_dn_ff);
endmodule : hsw_head_write

// [hsw_ctrl_model.sv]
// Purpose: Disc controller model facing the write interface of the drive
// Assumes: Changes its lines 10 ns after each sys_clk rising edge
// Notes:   Echo adds 10 ns of cable delay; free data wiggles when idle
`timescale 1ns/1ps

module hsw_ctrl_model
(
    input  wire logic sys_clk,
    input  wire logic base_clk,
    input  wire logic gate_req,
    input  wire logic nrz_bit,
    output logic      write_clk,
    output logic      write_gate,
    output logic      write_data_nrz
);
    // ==================================================
    // Write clock echo and gated data
    initial
    begin
        write_clk      = 1'b0;
        write_gate     = 1'b0;
        write_data_nrz = 1'b0;
    end

    // Data changes on the falling echo so it is settled at the rising one
    always @(posedge sys_clk)
    begin
        #10;
        write_clk  <= base_clk;
        write_gate <= gate_req;
        if (!gate_req)
            write_data_nrz <= ~write_data_nrz;             // Released line, not a stale level
        else if (write_clk && !base_clk)
            write_data_nrz <= nrz_bit;
    end
endmodule : hsw_ctrl_model

// [head_select_write_clocking_tb.sv]
// Purpose: Self-checking bench for head select decode and write clocking
// Assumes: VCO and reference are slow levels made here; controller is modelled
// Notes:   Exact encoder patterns are not compared, only toggle behaviour
`timescale 1ns/1ps

module head_select_write_clocking_tb
    import hsw_pkg::*;
;
    // ==================================================
    // Signals and instances
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       on_cylinder = 1'b0;
    logic       head_sel_cmd = 1'b0;
    logic [3:0] head_number = 4'h0;
    logic       fault_clear = 1'b0;
    logic       servo_decoding = 1'b0;
    logic       vco_clk_in = 1'b0;
    logic       ref_clk_in = 1'b0;
    logic       gate_req = 1'b0;
    logic       nrz_bit = 1'b0;
    logic [3:0] cur;
    logic       wc, wg, wd;
    hsw_sel_t   sel_out;
    hsw_pll_t   pll_out;
    hsw_wr_t    wr_out;
    int         failures = 0;
    int         checked = 0;
    int         nb, nh, np, nd, nc, i;

    hsw_head_write i_dut (.sys_clk(sys_clk), .nrst(nrst), .on_cylinder(on_cylinder),
        .head_sel_cmd(head_sel_cmd), .head_number(head_number), .write_gate(wg),
        .write_data_nrz(wd), .write_clk_in(wc), .fault_clear(fault_clear),
        .servo_decoding(servo_decoding), .vco_clk_in(vco_clk_in), .ref_clk_in(ref_clk_in),
        .sel_out(sel_out), .pll_out(pll_out), .wr_out(wr_out));

    hsw_ctrl_model i_ctrl (.sys_clk(sys_clk), .base_clk(pll_out.base_clk), .gate_req(gate_req),
        .nrz_bit(nrz_bit), .write_clk(wc), .write_gate(wg), .write_data_nrz(wd));

    // ==================================================
    // Clocks: ref period is slightly off twelve VCO periods so phase drifts
    initial forever #50 sys_clk = ~sys_clk;
    initial forever begin repeat (2) @(posedge sys_clk); #10; vco_clk_in = ~vco_clk_in; end
    initial forever begin repeat (25) @(posedge sys_clk); #10; ref_clk_in = ~ref_clk_in; end
    initial forever begin @(posedge sys_clk); #10; nrz_bit = 1'($urandom); end

    // ==================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : step

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Arm enable per head number, bit 0 is arm 1
    function automatic logic [7:0] exp_arm(input logic [3:0] h);
        logic [7:0] arms [0:7];
        arms = '{8'h20, 8'h40, 8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
        return (h == 4'hf) ? 8'h00 : arms[h[3:1]];
    endfunction : exp_arm

    task automatic select(input logic [3:0] h, input logic oc);
        head_sel_cmd = 1'b1;
        head_number  = h;
        on_cylinder  = oc;
        step(1);
        head_sel_cmd = 1'b0;
        head_number  = 4'($urandom);
        if (oc)
            cur = h;
        step(1);
        check(sel_out.arm_en, exp_arm(cur), "arm enable");
        check(8'(sel_out.head_choice), 8'(cur[0]), "head choice");
        check(8'(sel_out.addr), 8'(cur), "holding register");
    endtask : select

    // Counts toggles of the loop clocks and write lines over n cycles
    task automatic window(input int n);
        hsw_pll_t p;
        hsw_wr_t  w;
        nb = 0; nh = 0; np = 0; nd = 0; nc = 0;
        p = pll_out;
        w = wr_out;
        repeat (n)
        begin
            step(1);
            nb += int'(pll_out.base_clk !== p.base_clk);
            nh += int'(pll_out.half_clk !== p.half_clk);
            np += int'(pll_out.pump_up || pll_out.pump_down);
            nd += int'(wr_out.data_p !== w.data_p);
            nc += int'(wr_out.data_n !== ~wr_out.data_p);
            p = pll_out;
            w = wr_out;
        end
    endtask : window

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // Watchdog against a hung sequence
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end

    // ==================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h4b05));
        cur = 4'h0;
        repeat (6) @(posedge sys_clk);
        #10;
        nrst = 1'b1;
        step(3);
        check({pll_out, wr_out}, 8'h01, "reset outputs");
        check(sel_out.arm_en, 8'h00, "reset selection");
        check({3'h0, sel_out.head_choice, sel_out.addr}, 8'h00, "reset holding register");
        // Every head number, back to back, including the illegal one
        for (i = 0; i < 16; i++)
            select(4'(i), 1'b1);
        // Random commands, off cylinder ones must leave selection alone
        repeat (40)
            select(4'($urandom), 1'($urandom));
        // Write with no legal head selected
        select(4'hf, 1'b1);
        gate_req = 1'b1;
        for (i = 0; i < 8 && wr_out.write_fault !== 1'b1; i++) step(1);
        check(8'(wr_out.write_fault), 8'h01, "write fault");
        check(8'(wr_out.write_enable), 8'h00, "enable on fault");
        gate_req    = 1'b0;
        fault_clear = 1'b1;
        step(2);
        fault_clear = 1'b0;
        step(1);
        check(8'(wr_out.write_fault), 8'h00, "fault cleared");
        // Loop stopped, then running
        window(40);
        check(8'(nb), 8'h00, "base clock while stopped");
        servo_decoding = 1'b1;
        step(20);
        window(160);
        check(8'(nb), 8'd40, "base clock toggles");
        check(8'(nh), 8'd20, "half clock toggles");
        check(8'(np > 0), 8'h01, "pump activity");
        // Legal write with random NRZ data
        select(4'h4, 1'b1);
        gate_req = 1'b1;
        for (i = 0; i < 8 && wr_out.write_enable !== 1'b1; i++) step(1);
        check(8'(wr_out.write_enable), 8'h01, "write enable");
        window(200);
        check(8'(nd > 0), 8'h01, "write data toggles");
        check(8'(nc), 8'h00, "complement lines");
        check(8'(wr_out.write_fault), 8'h00, "no fault");
        gate_req = 1'b0;
        step(4);
        window(100);
        check(8'(wr_out.write_enable), 8'h00, "enable after gate");
        check(8'(nd), 8'h00, "no toggles without gate");
        end_of_test();
    end
endmodule : head_select_write_clocking_tb
